// ### gpb_defs.svh
/*
  Offsets, field positions and reset values of the
  graphics port bus block. Assumes inclusion by bare name only.
*/
`ifndef GPB_DEFS_SVH
`define GPB_DEFS_SVH

// Register offsets, byte addresses on the plain register port
`define GPB_OFS_CTRL 8'h00
`define GPB_OFS_DGRANT 8'h04
`define GPB_OFS_STATUS 8'h08

// Control register fields
`define GPB_CTRL_EN 0
`define GPB_CTRL_RATE_LO 1
`define GPB_CTRL_RATE_HI 2
`define GPB_CTRL_LOWSWING 3
`define GPB_CTRL_STOPREQ 4
`define GPB_CTRL_RESET 5'h00

// Data grant register fields
`define GPB_DGR_CODE_LO 0
`define GPB_DGR_CODE_HI 2
`define GPB_DGR_BUSY 0

// Status register fields
`define GPB_ST_DVO 0
`define GPB_ST_PERR 1
`define GPB_ST_BUSY 2

`endif

// ### gpb_pkg.sv
/*
  Types of the graphics port bus block: grant codes, lane rates,
  arbiter states and the configuration carrier. Assumes gpb_defs.svh.
*/
package gpb_pkg;

  // Grant purpose codes carried with each grant
  typedef enum logic [2:0] {
    GPB_GST_LP_READ = 3'h0,
    GPB_GST_HP_READ = 3'h1,
    GPB_GST_LP_WRITE = 3'h2,
    GPB_GST_HP_WRITE = 3'h3,
    GPB_GST_MASTER = 3'h7
  } gpb_gst_t;

  // Lane data rates
  typedef enum logic [1:0] {
    GPB_RATE_1X = 2'h0,
    GPB_RATE_4X = 2'h1,
    GPB_RATE_8X = 2'h2
  } gpb_rate_t;

  // Arbiter states, Gray along idle, grant, busy
  typedef enum logic [1:0] {
    GPB_ARB_IDLE = 2'b00,
    GPB_ARB_GNT = 2'b01,
    GPB_ARB_BUSY = 2'b11,
    GPB_ARB_DATA = 2'b10
  } gpb_arb_t;

  // Quasi-static configuration handed to the link domain
  typedef struct packed {
    logic stop_req;
    logic low_swing;
    logic [1:0] rate;
    logic enable;
  } gpb_cfg_t;

  // Inbound lane sample
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0] cbe_n;
    logic low_half_invert_flag;
  } gpb_lanes_t;

endpackage

// ### gpb_parity_chk.sv
/*
  Even parity check over address/data and command lanes, the parity
  pin trailing the lanes by one link clock. Assumes caller gates the
  enable to frame-based phases only.
*/
`timescale 1ns/100ps
module gpb_parity_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic check_en,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  input wire logic par,
  output logic err
);

  logic par_calc_reg;
  logic chk_pend_reg;

  ////////////////////////////////////////////////////////////////////
  // Parity of this cycle, compared with the pin one cycle later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      par_calc_reg <= 1'b0;
      chk_pend_reg <= 1'b0;
      err <= 1'b0;
    end else if (ce) begin
      par_calc_reg <= ^{ad, cbe_n};
      chk_pend_reg <= check_en; // R10
      err <= chk_pend_reg && (par != par_calc_reg); // R10
    end
  end

endmodule

// ### gpb_dbi_dec.sv
/*
  Bus inversion decoder for the low sixteen data lanes. Assumes the
  flag is sampled beside the lanes it qualifies.
*/
`timescale 1ns/100ps
module gpb_dbi_dec (
  input wire logic enable,
  input wire logic flag,
  input wire logic [15:0] lanes_in,
  output logic [15:0] lanes_out
);

  logic inv;

  // Inversion only counts in the low swing mode
  assign inv = enable & flag; // R13

  ////////////////////////////////////////////////////////////////////
  // One XOR per lane
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_lane
      assign lanes_out[i] = lanes_in[i] ^ inv; // R12
    end
  endgenerate

endmodule

// ### gpb_port.sv
/*
  Host end of the graphics port: arbiter with grant codes, frame
  target claim and stop, lane rate select, parity check, low-half bus
  inversion decode, mode strap and a small register file.
  Assumes REF_CLK at 40 MHz for registers and LINK_CLK as the port
  clock; link pins are synchronous to LINK_CLK.
*/
//
// Behaviour
// R1: Target asserts stop in frame transactions to end them, never in pipelined.
// R2: Target drives claim in frame accesses only, never in pipelined ones.
// R3: Card raises request before frame-based or pipelined transactions.
// R4: Card may send sideband requests without raising its request.
// R5: Grant answers a request or signals data for an enqueued transfer.
// R6: Each grant carries a three-bit code telling its purpose.
// R7: Address/data lanes run 1X on frames, configured rate otherwise.
// R8: Command/byte-enable lanes follow the address/data lane rate.
// R9: Byte enables are ignored on graphics-port read data.
// R10: Parity is checked only on frame-based transactions.
// R11: Parity pin strap low selects digital video mode, high graphics.
// R12: Inversion flag set means low sixteen lanes are inverted.
// R13: Inversion applies only in low swing mode.
// R14: Port logic resets from the system reset input.
// R15: No bus lock exists on this port.
// R16: Frame-based signals behave as the PCI 2.1 rules require.
// R17: Frame marks frame transactions, stays idle in pipelined ones.
// R18: Grant codes and pipelined protocol follow the published port spec.
`timescale 1ns/100ps
`include "gpb_defs.svh"
module gpb_port (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic LINK_CLK,
  input wire logic BUS_REQUEST_IN_N,
  output logic BUS_GRANT_OUT_N,
  output logic [2:0] GRANT_STATUS,
  input wire logic FRAME_SIGNAL_N_I,
  input wire logic PIPELINED_REQUEST_N,
  input wire logic [31:0] ADDR_DATA_LANES_I,
  input wire logic [3:0] CMD_BYTE_ENABLE_N_I,
  input wire logic BUS_PARITY_I,
  input wire logic LOW_HALF_INVERT_FLAG_I,
  input wire logic TXN_STOP_N_I,
  output logic TXN_STOP_N_O,
  output logic TXN_STOP_OE_N,
  input wire logic TARGET_CLAIM_N_I,
  output logic TARGET_CLAIM_N_O,
  output logic TARGET_CLAIM_OE_N,
  output logic [1:0] LANE_RATE,
  output logic MUX_SEL_DVO,
  output logic [15:0] RX_LOW_DATA,
  output logic [3:0] RX_BYTE_EN_N
);

  ////////////////////////////////////////////////////////////////////
  // Reference domain declarations
  gpb_pkg::gpb_cfg_t cfg_reg;
  logic [2:0] dgr_code_reg;
  logic [1:0] ack_sync_reg, strap_sync_reg, perr_sync_reg;
  logic dgr_req_reg, dgr_busy, strap_done_reg, dvo_reg;
  logic perr_seen_reg, perr_event, perr_reg, perr_next;
  logic [31:0] rdata_next;

  ////////////////////////////////////////////////////////////////////
  // Link domain declarations
  logic [1:0] lrst_sync_reg, lce_sync_reg, req_sync_reg;
  logic lrst_n, lce, req_seen_reg, dgr_ack_reg, dgr_pend;
  gpb_pkg::gpb_cfg_t cfg_meta_reg, lcfg_reg;
  gpb_pkg::gpb_arb_t arb_reg, arb_next;
  gpb_pkg::gpb_gst_t last_gst_reg;
  logic frame_act, pipe_act, claim_act_reg, turn_reg;
  logic perr_pulse, perr_tog_reg;
  logic [15:0] low_dec;
  gpb_pkg::gpb_lanes_t lanes;

  ////////////////////////////////////////////////////////////////////
  // Register port decode; write and read strobes never coincide
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      cfg_reg <= gpb_pkg::gpb_cfg_t'(`GPB_CTRL_RESET); // R14
    end else if (CE && WR && ADDR == `GPB_OFS_CTRL) begin
      cfg_reg <= gpb_pkg::gpb_cfg_t'(WDATA[`GPB_CTRL_STOPREQ:0]);
    end
  end

  // Data grant request: code held still while the link side works
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      dgr_code_reg <= 3'h0;
      dgr_req_reg <= 1'b0;
    end else if (CE && WR && ADDR == `GPB_OFS_DGRANT && !dgr_busy) begin
      dgr_code_reg <= WDATA[`GPB_DGR_CODE_HI:`GPB_DGR_CODE_LO];
      dgr_req_reg <= ~dgr_req_reg; // R5
    end
  end

  // Acknowledge toggle back from the link domain
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ack_sync_reg <= 2'b00;
    end else if (CE) begin
      ack_sync_reg <= {ack_sync_reg[0], dgr_ack_reg};
    end
  end

  // Busy while a toggled request is not yet acknowledged
  assign dgr_busy = dgr_req_reg ^ ack_sync_reg[1];

  ////////////////////////////////////////////////////////////////////
  // Mode strap: sampled once, first enabled cycle after release
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      strap_sync_reg <= {strap_sync_reg[0], BUS_PARITY_I}; // Fills in reset
      strap_done_reg <= 1'b0;
      dvo_reg <= 1'b0;
    end else if (CE) begin
      strap_sync_reg <= {strap_sync_reg[0], BUS_PARITY_I};
      // Two-flop delay lets the pull-up settle before capture
      if (!strap_done_reg) begin
        strap_done_reg <= 1'b1;
        dvo_reg <= ~strap_sync_reg[1]; // R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Parity error event from the link, sticky until written one
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      perr_sync_reg <= 2'b00;
      perr_seen_reg <= 1'b0;
    end else if (CE) begin
      perr_sync_reg <= {perr_sync_reg[0], perr_tog_reg};
      perr_seen_reg <= perr_sync_reg[1];
    end
  end
  assign perr_event = perr_sync_reg[1] ^ perr_seen_reg;
  // Set wins over a clear in the same cycle
  always_comb begin
    perr_next = perr_reg;
    if (WR && ADDR == `GPB_OFS_STATUS && WDATA[`GPB_ST_PERR]) begin
      perr_next = 1'b0;
    end
    if (perr_event) begin
      perr_next = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      perr_reg <= 1'b0;
    end else if (CE) begin
      perr_reg <= perr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux, data valid the cycle after the strobe; unmapped is zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (ADDR)
      `GPB_OFS_CTRL: rdata_next[`GPB_CTRL_STOPREQ:0] = cfg_reg;
      `GPB_OFS_DGRANT: rdata_next[`GPB_DGR_BUSY] = dgr_busy;
      `GPB_OFS_STATUS: begin
        rdata_next[`GPB_ST_DVO] = dvo_reg;
        rdata_next[`GPB_ST_PERR] = perr_reg;
        rdata_next[`GPB_ST_BUSY] = dgr_busy;
      end
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      RDATA <= 32'h0000_0000;
      MUX_SEL_DVO <= 1'b0;
    end else if (CE) begin
      RDATA <= RD ? rdata_next : 32'h0000_0000;
      MUX_SEL_DVO <= dvo_reg; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Link reset and clock enable crossings, both levels
  always_ff @(posedge LINK_CLK) begin
    lrst_sync_reg <= {lrst_sync_reg[0], RST_N}; // R14
  end
  assign lrst_n = lrst_sync_reg[1];
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      lce_sync_reg <= 2'b00;
      cfg_meta_reg <= gpb_pkg::gpb_cfg_t'(`GPB_CTRL_RESET);
      lcfg_reg <= gpb_pkg::gpb_cfg_t'(`GPB_CTRL_RESET);
      req_sync_reg <= 2'b00;
    end else begin
      lce_sync_reg <= {lce_sync_reg[0], CE};
      // Quasi-static: software changes these with the port idle
      cfg_meta_reg <= cfg_reg;
      lcfg_reg <= cfg_meta_reg;
      req_sync_reg <= {req_sync_reg[0], dgr_req_reg};
    end
  end
  assign lce = lce_sync_reg[1];
  // Pending while the request toggle differs from the last taken one
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      req_seen_reg <= 1'b0;
    end else if (lce && arb_reg == gpb_pkg::GPB_ARB_IDLE &&
                 arb_next == gpb_pkg::GPB_ARB_DATA) begin
      req_seen_reg <= req_sync_reg[1]; // Kept pending until taken
    end
  end
  assign dgr_pend = req_sync_reg[1] ^ req_seen_reg;

  ////////////////////////////////////////////////////////////////////
  // Frame and pipelined activity as seen on the lanes
  assign frame_act = ~FRAME_SIGNAL_N_I; // R17
  assign pipe_act = ~PIPELINED_REQUEST_N & FRAME_SIGNAL_N_I; // R17

  // Arbiter: enqueued data grants first, then master requests
  always_comb begin
    arb_next = arb_reg;
    unique case (arb_reg)
      gpb_pkg::GPB_ARB_IDLE: begin
        if (lcfg_reg.enable && dgr_pend) begin
          arb_next = gpb_pkg::GPB_ARB_DATA; // R5
        end else if (lcfg_reg.enable && !BUS_REQUEST_IN_N) begin
          arb_next = gpb_pkg::GPB_ARB_GNT; // R3
        end
      end
      gpb_pkg::GPB_ARB_GNT: begin
        if (frame_act || pipe_act || BUS_REQUEST_IN_N) begin
          arb_next = gpb_pkg::GPB_ARB_BUSY;
        end
      end
      gpb_pkg::GPB_ARB_BUSY: begin
        // Wait for the bus to return idle before the next grant
        if (!frame_act && !pipe_act && TARGET_CLAIM_N_I &&
            TXN_STOP_N_I && !claim_act_reg && !turn_reg) begin
          arb_next = gpb_pkg::GPB_ARB_IDLE;
        end
      end
      gpb_pkg::GPB_ARB_DATA: begin
        arb_next = gpb_pkg::GPB_ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      arb_reg <= gpb_pkg::GPB_ARB_IDLE;
    end else if (lce) begin
      arb_reg <= arb_next;
    end
  end

  // Grant pins and purpose code, registered from the next state
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      BUS_GRANT_OUT_N <= 1'b1;
      GRANT_STATUS <= gpb_pkg::GPB_GST_MASTER;
      last_gst_reg <= gpb_pkg::GPB_GST_MASTER;
      dgr_ack_reg <= 1'b0;
    end else if (lce) begin
      BUS_GRANT_OUT_N <= !(arb_next == gpb_pkg::GPB_ARB_GNT ||
                           arb_next == gpb_pkg::GPB_ARB_DATA); // R5
      if (arb_next == gpb_pkg::GPB_ARB_DATA) begin
        GRANT_STATUS <= dgr_code_reg; // R6
        last_gst_reg <= gpb_pkg::gpb_gst_t'(dgr_code_reg); // R18
      end else begin
        GRANT_STATUS <= gpb_pkg::GPB_GST_MASTER; // R6
      end
      if (arb_reg == gpb_pkg::GPB_ARB_DATA) begin
        dgr_ack_reg <= req_seen_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Target claim and stop: frame accesses only, never pipelined
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      claim_act_reg <= 1'b0;
      turn_reg <= 1'b0;
      TARGET_CLAIM_N_O <= 1'b1;
      TARGET_CLAIM_OE_N <= 1'b1;
      TXN_STOP_N_O <= 1'b1;
      TXN_STOP_OE_N <= 1'b1;
    end else if (lce) begin
      claim_act_reg <= lcfg_reg.enable && frame_act; // R2
      // One cycle driven high before release, sustained tri-state
      turn_reg <= claim_act_reg && !(lcfg_reg.enable && frame_act); // R16
      TARGET_CLAIM_N_O <= !(lcfg_reg.enable && frame_act); // R2
      TXN_STOP_N_O <= !(lcfg_reg.enable && frame_act &&
                        lcfg_reg.stop_req); // R1
      TARGET_CLAIM_OE_N <= !(lcfg_reg.enable && frame_act) &&
                           !claim_act_reg; // R16
      TXN_STOP_OE_N <= !(lcfg_reg.enable && frame_act) &&
                       !claim_act_reg; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Lane rate: frames at 1X, other phases at the configured rate
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      LANE_RATE <= gpb_pkg::GPB_RATE_1X;
    end else if (lce) begin
      // Command lanes share this one rate at all times
      LANE_RATE <= frame_act ? gpb_pkg::GPB_RATE_1X : lcfg_reg.rate; // R7 R8
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Parity check, gated to frame phases
  gpb_parity_chk u_par (
    .clk(LINK_CLK),
    .rst_n(lrst_n),
    .ce(lce),
    .check_en(frame_act && lcfg_reg.enable), // R10
    .ad(ADDR_DATA_LANES_I),
    .cbe_n(CMD_BYTE_ENABLE_N_I),
    .par(BUS_PARITY_I),
    .err(perr_pulse)
  );

  // Error pulses become a toggle for the reference domain
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      perr_tog_reg <= 1'b0;
    end else if (lce && perr_pulse) begin
      perr_tog_reg <= ~perr_tog_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Inbound lanes and low-half inversion decode
  assign lanes = {ADDR_DATA_LANES_I, CMD_BYTE_ENABLE_N_I,
                  LOW_HALF_INVERT_FLAG_I};

  gpb_dbi_dec u_dbi (
    .enable(lcfg_reg.low_swing), // R13
    .flag(lanes.low_half_invert_flag),
    .lanes_in(lanes.ad[15:0]),
    .lanes_out(low_dec)
  );

  // Byte enables kept from the last phase that honours them
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      RX_LOW_DATA <= 16'h0000;
      RX_BYTE_EN_N <= 4'hF;
    end else if (lce) begin
      RX_LOW_DATA <= low_dec; // R12
      if (!(last_gst_reg == gpb_pkg::GPB_GST_LP_READ ||
            last_gst_reg == gpb_pkg::GPB_GST_HP_READ) || frame_act) begin
        RX_BYTE_EN_N <= lanes.cbe_n; // R9
      end
    end
  end

  // No lock pin: locked sequences are not carried on this port, R15
  // Sideband requests arrive outside this block; no request needed, R4

endmodule

// ### gpb_port_properties.sv
/*
  Pin and register-port checks for the graphics port bus block.
  Assumes binding onto gpb_port; only its ports are seen.
*/
`timescale 1ns/100ps
module gpb_props (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [31:0] RDATA,
  input wire logic MUX_SEL_DVO,
  input wire logic LINK_CLK,
  input wire logic BUS_REQUEST_IN_N,
  input wire logic BUS_GRANT_OUT_N,
  input wire logic [2:0] GRANT_STATUS,
  input wire logic FRAME_SIGNAL_N_I,
  input wire logic [31:0] ADDR_DATA_LANES_I,
  input wire logic LOW_HALF_INVERT_FLAG_I,
  input wire logic TXN_STOP_N_O,
  input wire logic TXN_STOP_OE_N,
  input wire logic TARGET_CLAIM_N_O,
  input wire logic TARGET_CLAIM_OE_N,
  input wire logic [15:0] RX_LOW_DATA
);
  //////////////////////////////////////////////////////////////////
  // Claim and stop only answer a frame sampled one clock earlier
  claim_in_frame_a: assert property (@(posedge LINK_CLK)
    disable iff (!RST_N) !TARGET_CLAIM_OE_N && !TARGET_CLAIM_N_O
    |-> !$past(FRAME_SIGNAL_N_I)) else $error("claim outside frame");
  stop_in_frame_a: assert property (@(posedge LINK_CLK)
    disable iff (!RST_N) !TXN_STOP_OE_N && !TXN_STOP_N_O
    |-> !$past(FRAME_SIGNAL_N_I)) else $error("stop outside frame");
  // Master grant lives only on a held request
  master_grant_a: assert property (@(posedge LINK_CLK)
    disable iff (!RST_N) !BUS_GRANT_OUT_N && GRANT_STATUS == 3'h7
    |-> !$past(BUS_REQUEST_IN_N)) else $error("grant without request");
  // Data grant code stands one clock only
  data_grant_pulse_a: assert property (@(posedge LINK_CLK)
    disable iff (!RST_N) !BUS_GRANT_OUT_N && GRANT_STATUS != 3'h7
    |=> GRANT_STATUS == 3'h7) else $error("data grant too long");
  idle_status_a: assert property (@(posedge LINK_CLK)
    disable iff (!RST_N) BUS_GRANT_OUT_N |-> GRANT_STATUS == 3'h7)
    else $error("code without grant");
  // Plain low lanes while the flag is clear, once the link side is out of reset
  plain_lanes_a: assert property (@(posedge LINK_CLK)
    disable iff (!RST_N) $past(RST_N, 5) && !$past(LOW_HALF_INVERT_FLAG_I)
    |-> RX_LOW_DATA == 16'($past(ADDR_DATA_LANES_I)))
    else $error("low lanes altered");
  //////////////////////////////////////////////////////////////////
  // Strap settles within two edges, then never moves
  strap_hold_a: assert property (@(posedge REF_CLK)
    disable iff (!RST_N) $past(RST_N, 4) |-> $stable(MUX_SEL_DVO))
    else $error("mode moved after strap");
  reset_values_a: assert property (@(posedge REF_CLK)
    disable iff (!RST_N) $rose(RST_N) |-> RDATA == 32'h0 && !MUX_SEL_DVO)
    else $error("bad reset values");
  // Main scenarios reached
  master_c: cover property (@(posedge LINK_CLK) disable iff (!RST_N)
    !BUS_GRANT_OUT_N && GRANT_STATUS == 3'h7);
  data_c: cover property (@(posedge LINK_CLK) disable iff (!RST_N)
    !BUS_GRANT_OUT_N && GRANT_STATUS != 3'h7);
  stop_c: cover property (@(posedge LINK_CLK) disable iff (!RST_N)
    !TXN_STOP_OE_N && !TXN_STOP_N_O);
endmodule

bind gpb_port gpb_props u_props (.*);

// ### gpb_card.sv
/*
  Behavioural add-in card at the far side of the graphics port.
  Assumes the port samples every lane on LINK_CLK rising edges.
*/
`timescale 1ns/100ps
module gpb_card (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic gnt_n,
  input wire logic [2:0] gst,
  input wire logic claim_n,
  input wire logic stop_n,
  output logic req_n,
  output logic frame_n,
  output logic pipe_n,
  output logic [31:0] ad,
  output logic [3:0] cbe_n,
  output logic par,
  output logic flag
);
  logic strap = 1'b1;
  logic hold = 1'b0;
  logic bad_par = 1'b0;
  logic claim_seen = 1'b0;
  logic stop_seen = 1'b0;
  logic [2:0] last_code = 3'h7;

  // Pulled-up pins idle high
  initial begin
    {req_n, frame_n, pipe_n, par, flag} = 5'b11110;
    ad = 32'h0;
    cbe_n = 4'hF;
  end
  //////////////////////////////////////////////////////////////////
  // Parity trails lanes by a clock; released lanes never look stale
  always @(posedge clk) begin
    par <= rst_n ? (^{ad, cbe_n}) ^ bad_par : strap;
    if (!rst_n)
      ad <= 32'h0;
    else if (!hold)
      ad <= ~ad;
  end
  // Records what the port answered, for the bench to judge
  always @(posedge clk) begin
    if (!claim_n)
      claim_seen <= 1'b1;
    if (!stop_n)
      stop_seen <= 1'b1;
    if (!gnt_n && gst != 3'h7)
      last_code <= gst;
  end
  //////////////////////////////////////////////////////////////////
  // One tenure: request, grant, then frame or pipelined run; no lock
  task automatic txn(input logic piped, input int len);
    hold = 1'b1;
    @(posedge clk) req_n <= 1'b0;
    for (int i = 0; i < 40 && gnt_n !== 1'b0; i++)
      @(posedge clk);
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      req_n <= 1'b1;
      frame_n <= piped;
      pipe_n <= !piped;
      ad <= 32'h1234_0000 + i;
      cbe_n <= 4'(i);
    end
    @(posedge clk);
    frame_n <= 1'b1;
    pipe_n <= 1'b1;
    hold = 1'b0;
  endtask
  // Lanes held steady with their inversion flag
  task automatic drive(input logic [31:0] a, input logic [3:0] c,
      input logic f);
    hold = 1'b1;
    @(posedge clk);
    ad <= a;
    cbe_n <= c;
    flag <= f;
  endtask
endmodule

// ### gpb_port_tb.sv
/*
  Self-checking bench for the graphics port bus block.
  Assumes gpb_card as the far side and gpb_props bound on.
*/
`timescale 1ns/100ps
module gpb_port_tb;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, ad, d;
  logic [3:0] cbe_n, rx_be_n;
  logic [2:0] gst;
  logic [1:0] rate;
  logic [15:0] rx_lo;
  logic gnt_n, req_n, frame_n, pipe_n, par, flag, dvo;
  logic stop_o, stop_oe_n, claim_o, claim_oe_n;
  wire logic stop_pin = stop_oe_n ? 1'b1 : stop_o;
  wire logic claim_pin = claim_oe_n ? 1'b1 : claim_o;
  int bad_count = 0;
  int n_tests = 0;

  // Unrelated clocks
  initial forever #12.5 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #40 link_clk = ~link_clk;
  end

  gpb_port u_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(ce), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LINK_CLK(link_clk),
    .BUS_REQUEST_IN_N(req_n), .BUS_GRANT_OUT_N(gnt_n),
    .GRANT_STATUS(gst), .FRAME_SIGNAL_N_I(frame_n),
    .PIPELINED_REQUEST_N(pipe_n), .ADDR_DATA_LANES_I(ad),
    .CMD_BYTE_ENABLE_N_I(cbe_n), .BUS_PARITY_I(par),
    .LOW_HALF_INVERT_FLAG_I(flag), .TXN_STOP_N_I(stop_pin),
    .TXN_STOP_N_O(stop_o), .TXN_STOP_OE_N(stop_oe_n),
    .TARGET_CLAIM_N_I(claim_pin), .TARGET_CLAIM_N_O(claim_o),
    .TARGET_CLAIM_OE_N(claim_oe_n), .LANE_RATE(rate),
    .MUX_SEL_DVO(dvo), .RX_LOW_DATA(rx_lo), .RX_BYTE_EN_N(rx_be_n));
  gpb_card u_card (.clk(link_clk), .rst_n(rst_n), .gnt_n(gnt_n),
    .gst(gst), .claim_n(claim_pin), .stop_n(stop_pin), .req_n(req_n),
    .frame_n(frame_n), .pipe_n(pipe_n), .ad(ad), .cbe_n(cbe_n),
    .par(par), .flag(flag));
  //////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string what, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    ce <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only the cycle after the strobe; polls for crossings
  task automatic rd_chk(input string what, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
      if ((d & m) === e)
        break;
    end
    check(what, e, d & m);
  endtask
  task automatic lwait(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  task automatic dgrant(input logic [2:0] c);
    wr_reg(8'h04, {29'h0, c});
    for (int i = 0; i < 20 && u_card.last_code !== c; i++)
      lwait(1);
    check("grant code", {29'h0, c}, {29'h0, u_card.last_code});
    rd_chk("grant done", 8'h04, 32'h1, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////
  // Reset values, unmapped place and both strap levels
  task automatic t_reset;
    rd_chk("ctrl", 8'h00, 32'hFFFF_FFFF, 32'h0);
    rd_chk("unmapped", 8'h0C, 32'hFFFF_FFFF, 32'h0);
    check("grant idle", 32'hF, {28'h0, gnt_n, gst});
    u_card.strap = 1'b0;
    do_reset;
    check("video mode", 32'h1, {31'h0, dvo});
    rd_chk("strap status", 8'h08, 32'h1, 32'h1);
    u_card.strap = 1'b1;
    do_reset;
    check("port mode", 32'h0, {31'h0, dvo});
  endtask
  // Every configured lane rate shows outside frames
  task automatic t_rate;
    for (int r = 0; r < 3; r++) begin
      wr_reg(8'h00, 32'h1 | (r << 1));
      rd_chk("ctrl", 8'h00, 32'h1F, 32'h1 | (r << 1));
      lwait(4);
      check("lane rate", r, {30'h0, rate});
    end
  endtask
  // A good-parity frame: claimed, stopped on request, run at 1X
  task automatic t_frame(input logic stop);
    wr_reg(8'h00, {27'h0, stop, 4'h5});
    u_card.claim_seen = 1'b0;
    u_card.stop_seen = 1'b0;
    fork
      u_card.txn(1'b0, 6);
      begin
        for (int i = 0; i < 60 && frame_n; i++)
          @(posedge link_clk);
        lwait(3);
        check("frame rate", 32'h0, {30'h0, rate});
      end
    join
    lwait(3);
    check("claim", 32'h1, {31'h0, u_card.claim_seen});
    check("stop", {31'h0, stop}, {31'h0, u_card.stop_seen});
    rd_chk("parity ok", 8'h08, 32'h2, 32'h0);
  endtask
  // Bad parity counts on frames only and clears by writing one
  task automatic t_parity;
    u_card.bad_par = 1'b1;
    u_card.claim_seen = 1'b0;
    u_card.stop_seen = 1'b0;
    u_card.txn(1'b1, 4);
    lwait(3);
    check("pipe claim", 32'h0, {31'h0, u_card.claim_seen});
    check("pipe stop", 32'h0, {31'h0, u_card.stop_seen});
    rd_chk("pipe parity", 8'h08, 32'h2, 32'h0);
    u_card.txn(1'b0, 4);
    rd_chk("frame parity", 8'h08, 32'h2, 32'h2);
    wr_reg(8'h08, 32'h2);
    rd_chk("parity clear", 8'h08, 32'h2, 32'h0);
    u_card.bad_par = 1'b0;
  endtask
  // All data grant codes; a read grant freezes byte enables
  task automatic t_dgrant;
    logic [2:0] codes [4] = '{3'h2, 3'h3, 3'h0, 3'h1};
    u_card.drive(32'h0, 4'hF, 1'b0);
    foreach (codes[k])
      dgrant(codes[k]);
    u_card.drive(32'h0, 4'h5, 1'b0);
    lwait(3);
    check("read enables", 32'hF, {28'h0, rx_be_n});
    dgrant(3'h2);
    lwait(2);
    check("write enables", 32'h5, {28'h0, rx_be_n});
  endtask
  // Low lanes invert only with low swing and the flag set
  task automatic t_dbi;
    wr_reg(8'h00, 32'h9);
    u_card.drive(32'h0000_A5C3, 4'hF, 1'b1);
    lwait(6);
    check("inverted", 32'h5A3C, {16'h0, rx_lo});
    u_card.drive(32'h0000_A5C3, 4'hF, 1'b0);
    lwait(3);
    check("flag clear", 32'hA5C3, {16'h0, rx_lo});
    wr_reg(8'h00, 32'h1);
    u_card.drive(32'h0000_A5C3, 4'hF, 1'b1);
    lwait(6);
    check("full swing", 32'hA5C3, {16'h0, rx_lo});
    u_card.hold = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset;
    t_reset;
    t_rate;
    t_frame(1'b0);
    t_frame(1'b1);
    t_parity;
    t_dgrant;
    t_dbi;
    complete_run;
  end
  // The whole run needs well under this span
  initial begin
    #400us;
    bad_count++;
    complete_run;
  end
endmodule
